/* hdl/hqs_port.sv */
// Purpose: host port that stacks byte/word accesses into quadlet accesses
// Assumes: host clock comes from the host; core side answers INT_REQ with INT_DONE
// Notes: host facing logic runs on HOST_CLOCK_OUT, internal port on CLK
// Notes on behaviour
// - a read missing the buffer starts one internal 32 bit quadlet read
// - handshake: hold host read until internal answer arrives, then release wait
// - whole quadlet kept; other positions of it are served from the buffer
// - internal read answer bounded to 19 core clocks
// - rereading an already read position starts a fresh read of that quadlet
// - a read to another quadlet starts a new internal read
// - any host write invalidates the buffered read quadlet
// - internal write starts only when all four bytes are loaded
// - full quadlet is passed on and the host released without waiting
// - while a write is outstanding only one further access is taken
// - on write answer the held access is launched and then released
// - byte and word writes inside one quadlet accepted in any order
// - partial write broken by other quadlet, read or repeat byte flags error
// - wait low soon after chip select falls, never longer than 17 clocks after the take (20 after select)
// - write data captured on first host clock edge after chip select low
// - data bus released asynchronously when chip select rises
// - blind mode: host polls a done status instead of waiting
// - internal access not done in 17 clocks is aborted and wait released
// - byte mode data on bits 7:0, bits 15:8 driven low, ignored on write
`timescale 1ns/10ps
`include "hqs_map.svh"

module hqs_port
  import hqs_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HOST_CLOCK_OUT,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_WRITE_N,
  input wire logic BYTE_MODE,
  input wire logic [`HQS_AW-1:0] HOST_ADDR,
  input wire logic [`HQS_DW-1:0] HOST_DATA_IN,
  output logic [`HQS_DW-1:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic PORT_WAIT_N,
  output logic XFER_DONE,
  output logic INT_REQ,
  output logic INT_WRITE,
  output logic [`HQS_AW-1:0] INT_ADDR,
  output logic [`HQS_QW-1:0] INT_WDATA,
  input wire logic INT_DONE,
  input wire logic [`HQS_QW-1:0] INT_RDATA,
  output logic INVALID_WRITE_FLAG
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // byte lanes touched by one host access
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic bmode);
    logic [3:0] m;
    m = `HQS_MASK_NONE;
    if (bmode) begin
      m[a] = 1'b1;
    end else begin
      m = a[1] ? `HQS_MASK_HI : `HQS_MASK_LO;
    end
    return m;
  endfunction

  // replace the lanes of a quadlet selected by mask with host data
  function automatic logic [31:0] merge(input logic [31:0] q, input logic [3:0] m,
                                        input logic [15:0] d, input logic bmode);
    logic [31:0] r;
    r = q;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        r[8*i +: 8] = (bmode || !i[0]) ? d[7:0] : d[15:8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // host clock domain: pin synchronisers and answer from the core domain
  // ----------------------------------------------------------------------
  logic cs_s1, cs_s2, cs_p, rw_s1, rw_s2, bm_s1, bm_s2;
  logic [`HQS_AW-1:0] addr_s1, addr_s2;
  logic [`HQS_DW-1:0] din_s1, din_s2;
  logic ack_tgl_q, ack_s1, ack_s2, ack_p, resp;
  logic [`HQS_QW-1:0] rdata_q;

  // address and data ride the same two stages as chip select
  always_ff @(posedge HOST_CLOCK_OUT or negedge NRST) begin
    if (!NRST) begin
      {cs_s1, cs_s2, cs_p, rw_s1, rw_s2} <= 5'h1f;
      {bm_s1, bm_s2, ack_s1, ack_s2, ack_p} <= 5'h00;
      {addr_s1, addr_s2, din_s1, din_s2} <= '0;
    end else begin
      {cs_p, cs_s2, cs_s1} <= {cs_s2, cs_s1, CHIP_SELECT_N};
      {rw_s2, rw_s1} <= {rw_s1, READ_WRITE_N};
      {bm_s2, bm_s1} <= {bm_s1, BYTE_MODE};
      {addr_s2, addr_s1} <= {addr_s1, HOST_ADDR};
      {din_s2, din_s1} <= {din_s1, HOST_DATA_IN};
      {ack_p, ack_s2, ack_s1} <= {ack_s2, ack_s1, ack_tgl_q};
    end
  end

  logic acc_start;
  assign acc_start = cs_p && !cs_s2;
  assign resp = ack_s2 ^ ack_p;

  // ----------------------------------------------------------------------
  // host clock domain: stacking buffer and sequencer
  // ----------------------------------------------------------------------
  hqs_state_t st_q;
  hqs_req_t req_q;
  logic req_tgl_q, busy_q, rd_valid_q, err_tgl_q, acc_rw_q, acc_bm_q;
  logic [`HQS_AW-1:0] acc_addr_q, rd_qaddr_q, wr_qaddr_q;
  logic [`HQS_DW-1:0] acc_data_q;
  logic [3:0] rd_seen_q, wr_mask_q;
  logic [31:0] rd_buf_q, wr_buf_q;
  logic [4:0] tmo_q;
  logic rd_out_q;

  logic [3:0] acc_m, wr_new;
  logic [`HQS_AW-1:0] acc_q;
  logic rd_hit, wr_clash, timed_out;
  assign acc_m = lane_mask(acc_addr_q[1:0], acc_bm_q);
  assign acc_q = {acc_addr_q[`HQS_AW-1:2], 2'b00};
  // hit only for the same quadlet and a position not read yet
  assign rd_hit = rd_valid_q && (rd_qaddr_q == acc_q) && ((rd_seen_q & acc_m) == 4'h0);
  // any order is fine, but not another quadlet or a repeated lane
  assign wr_clash = (wr_mask_q != `HQS_MASK_NONE) &&
                    ((wr_qaddr_q != acc_q) || ((wr_mask_q & acc_m) != 4'h0));
  assign wr_new = wr_clash ? acc_m : (wr_mask_q | acc_m);
  // counted from the take, so wait rises no later than 17 host clocks after it
  assign timed_out = (tmo_q == `HQS_WAIT_MAX_BCLK - 5'd2);

  // main sequencer; holding in EVAL while busy keeps a third access out
  always_ff @(posedge HOST_CLOCK_OUT or negedge NRST) begin
    if (!NRST) begin
      st_q <= HS_IDLE;
      req_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_seen_q <= 4'h0;
      rd_qaddr_q <= '0;
      rd_buf_q <= '0;
      wr_mask_q <= `HQS_MASK_NONE;
      wr_qaddr_q <= '0;
      wr_buf_q <= '0;
      err_tgl_q <= 1'b0;
      acc_rw_q <= 1'b1;
      acc_bm_q <= 1'b0;
      acc_addr_q <= '0;
      acc_data_q <= '0;
      tmo_q <= 5'd0;
      rd_out_q <= 1'b0;
    end else begin
      if (st_q == HS_IDLE || st_q == HS_DONE) begin
        tmo_q <= 5'd0;
      end else if (!timed_out) begin
        tmo_q <= tmo_q + 5'd1;
      end
      // an answer always frees the internal port, even after an abort
      if (resp) begin
        busy_q <= 1'b0;
      end
      unique case (st_q)
        HS_IDLE: begin
          rd_out_q <= 1'b0;
          if (acc_start) begin
            acc_rw_q <= rw_s2;
            acc_bm_q <= bm_s2;
            acc_addr_q <= addr_s2;
            acc_data_q <= bm_s2 ? {8'h00, din_s2[7:0]} : din_s2;
            st_q <= HS_EVAL;
          end
        end
        HS_EVAL: begin
          if (timed_out) begin
            st_q <= HS_DONE;
          end else if (busy_q && !resp) begin
            st_q <= HS_EVAL;
          end else if (acc_rw_q) begin
            if (wr_mask_q != `HQS_MASK_NONE) begin
              wr_mask_q <= `HQS_MASK_NONE;
              err_tgl_q <= ~err_tgl_q;
            end
            if (rd_hit) begin
              rd_seen_q <= rd_seen_q | acc_m;
              rd_out_q <= 1'b1;
              st_q <= HS_DONE;
            end else begin
              req_q <= '{write: 1'b0, addr: acc_q, wdata: '0};
              req_tgl_q <= ~req_tgl_q;
              busy_q <= 1'b1;
              st_q <= HS_WAIT_INT;
            end
          end else begin
            rd_valid_q <= 1'b0;
            if (wr_clash) begin
              err_tgl_q <= ~err_tgl_q;
            end
            if (wr_new == `HQS_MASK_FULL) begin
              // pass the quadlet on and release the host at once
              req_q <= '{write: 1'b1, addr: acc_q,
                         wdata: merge(wr_buf_q, acc_m, acc_data_q, acc_bm_q)};
              req_tgl_q <= ~req_tgl_q;
              busy_q <= 1'b1;
              wr_mask_q <= `HQS_MASK_NONE;
            end else begin
              wr_mask_q <= wr_new;
              wr_qaddr_q <= acc_q;
              wr_buf_q <= merge(wr_buf_q, acc_m, acc_data_q, acc_bm_q);
            end
            st_q <= HS_DONE;
          end
        end
        HS_WAIT_INT: begin
          if (resp) begin
            rd_buf_q <= rdata_q;
            rd_qaddr_q <= req_q.addr;
            rd_valid_q <= 1'b1;
            rd_seen_q <= acc_m;
            rd_out_q <= 1'b1;
            st_q <= HS_DONE;
          end else if (timed_out) begin
            st_q <= HS_DONE;
          end
        end
        HS_DONE: begin
          if (cs_s2) begin
            st_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // host clock domain: pins
  // ----------------------------------------------------------------------
  // wait idles asserted so that it is already low when a select arrives;
  // the synchroniser would otherwise make it too late for the host
  always_ff @(posedge HOST_CLOCK_OUT or negedge NRST) begin
    if (!NRST) begin
      PORT_WAIT_N <= 1'b0;
      XFER_DONE <= 1'b1;
      HOST_DATA_OUT <= '0;
    end else begin
      PORT_WAIT_N <= (st_q == HS_DONE) && !cs_s2;
      XFER_DONE <= !busy_q && (st_q != HS_WAIT_INT);
      if (st_q == HS_DONE && rd_out_q) begin
        if (acc_bm_q) begin
          HOST_DATA_OUT <= {8'h00, rd_buf_q[8*acc_addr_q[1:0] +: 8]};
        end else begin
          HOST_DATA_OUT <= rd_buf_q[16*acc_addr_q[1] +: 16];
        end
      end
    end
  end

  // drive enable is cleared by the select pin itself, not a clock edge
  always_ff @(posedge HOST_CLOCK_OUT or negedge NRST or posedge CHIP_SELECT_N) begin
    if (!NRST) begin
      HOST_DATA_OE <= 1'b0;
    end else if (CHIP_SELECT_N) begin
      HOST_DATA_OE <= 1'b0;
    end else begin
      HOST_DATA_OE <= (st_q == HS_DONE) && rd_out_q;
    end
  end

  // ----------------------------------------------------------------------
  // core clock domain: internal port
  // ----------------------------------------------------------------------
  logic req_s1, req_s2, req_p, act_q, err_s1, err_s2, err_p;
  logic [4:0] lat_q;

  // request words are held stable by the host side until the answer toggles
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_p <= 1'b0;
      err_s1 <= 1'b0;
      err_s2 <= 1'b0;
      err_p <= 1'b0;
      INVALID_WRITE_FLAG <= 1'b0;
    end else begin
      req_s1 <= req_tgl_q;
      req_s2 <= req_s1;
      req_p <= req_s2;
      err_s1 <= err_tgl_q;
      err_s2 <= err_s1;
      err_p <= err_s2;
      INVALID_WRITE_FLAG <= err_s2 ^ err_p;
    end
  end

  // one outstanding internal access; a late answer is cut off with zero data
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_q <= 1'b0;
      lat_q <= 5'd0;
      ack_tgl_q <= 1'b0;
      rdata_q <= '0;
      INT_REQ <= 1'b0;
      INT_WRITE <= 1'b0;
      INT_ADDR <= '0;
      INT_WDATA <= '0;
    end else begin
      INT_REQ <= 1'b0;
      if (!act_q && (req_s2 ^ req_p)) begin
        act_q <= 1'b1;
        lat_q <= 5'd1;
        INT_REQ <= 1'b1;
        INT_WRITE <= req_q.write;
        INT_ADDR <= req_q.addr;
        INT_WDATA <= req_q.wdata;
      end else if (act_q) begin
        lat_q <= lat_q + 5'd1;
        if (INT_DONE || lat_q == `HQS_INT_LAT_MAX - 5'd1) begin
          act_q <= 1'b0;
          rdata_q <= INT_DONE ? INT_RDATA : '0;
          ack_tgl_q <= ~ack_tgl_q;
        end
      end
    end
  end

endmodule

/* shared/hqs_map.svh */
// Purpose: constants of the quadlet stacking host port
// Assumes: byte addresses of 9 bits, 16 bit host data bus
// Notes: counts are in cycles of the clock named beside each one
`ifndef HQS_MAP_SVH
`define HQS_MAP_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define HQS_AW 9
`define HQS_DW 16
`define HQS_QW 32

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
// longest wait low time after the take in host clock cycles
`define HQS_WAIT_MAX_BCLK 5'd17
// longest internal read latency in core clock cycles
`define HQS_INT_LAT_MAX 5'd19

// ----------------------------------------------------------------------
// byte masks
// ----------------------------------------------------------------------
`define HQS_MASK_NONE 4'h0
`define HQS_MASK_FULL 4'hf
`define HQS_MASK_LO 4'h3
`define HQS_MASK_HI 4'hc

`endif

/* shared/hqs_pkg.sv */
// Purpose: types of the quadlet stacking host port
// Assumes: hqs_map.svh holds the numbers
// Notes: none
`include "hqs_map.svh"

package hqs_pkg;

  // ----------------------------------------------------------------------
  // internal request carried from host clock to core clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [`HQS_AW-1:0] addr;
    logic [`HQS_QW-1:0] wdata;
  } hqs_req_t;

  // ----------------------------------------------------------------------
  // host side access sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_EVAL,
    HS_WAIT_INT,
    HS_DONE
  } hqs_state_t;

endpackage

/* testbench/hqs_port_chk.sv */
// Purpose: concurrent checks on the quadlet stacking host port
// Assumes: sees only the top module ports
// Notes: host side checks run on the host clock except the bus release check, which runs on CLK with the core side checks
`timescale 1ns/10ps
`include "hqs_map.svh"
module hqs_port_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HOST_CLOCK_OUT,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_WRITE_N,
  input wire logic BYTE_MODE,
  input wire logic [`HQS_DW-1:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE,
  input wire logic PORT_WAIT_N,
  input wire logic INT_REQ,
  input wire logic [`HQS_AW-1:0] INT_ADDR,
  input wire logic INVALID_WRITE_FLAG
);
  logic [5:0] wlow_q;
  // host clocks of wait inside one select: 3 to take it plus the 17 clock limit
  always_ff @(posedge HOST_CLOCK_OUT or negedge NRST) begin
    if (!NRST) begin
      wlow_q <= 6'h00;
    end else if (!CHIP_SELECT_N && !PORT_WAIT_N) begin
      wlow_q <= wlow_q + 6'h01;
    end else begin
      wlow_q <= 6'h00;
    end
  end
  wait_bound_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    wlow_q <= 6'h14) else $error("wait held low too long");
  wait_start_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    $fell(CHIP_SELECT_N) |-> !PORT_WAIT_N [*3]) else $error("wait not low at select start");
  wait_idle_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    CHIP_SELECT_N [*5] |-> !PORT_WAIT_N) else $error("wait not back low when idle");
  oe_read_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    $rose(HOST_DATA_OE) |-> READ_WRITE_N && !CHIP_SELECT_N) else $error("drive outside read");
  data_hold_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    HOST_DATA_OE && $past(HOST_DATA_OE) |-> $stable(HOST_DATA_OUT))
    else $error("read data moved while driven");
  byte_high_a: assert property (@(posedge HOST_CLOCK_OUT) disable iff (!NRST)
    HOST_DATA_OE && BYTE_MODE |-> HOST_DATA_OUT[15:8] == 8'h00) else $error("upper byte not low");
  oe_off_a: assert property (@(posedge CLK) disable iff (!NRST)
    CHIP_SELECT_N |-> !HOST_DATA_OE) else $error("bus driven without select");
  req_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
    INT_REQ |=> !INT_REQ) else $error("request longer than one cycle");
  req_align_a: assert property (@(posedge CLK) disable iff (!NRST)
    INT_REQ |-> INT_ADDR[1:0] == 2'b00) else $error("request not quadlet aligned");
  flag_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
    INVALID_WRITE_FLAG |=> !INVALID_WRITE_FLAG) else $error("flag longer than one cycle");
endmodule

bind hqs_port hqs_port_chk hqs_port_chk_i (
  .CLK(CLK), .NRST(NRST), .HOST_CLOCK_OUT(HOST_CLOCK_OUT), .CHIP_SELECT_N(CHIP_SELECT_N),
  .READ_WRITE_N(READ_WRITE_N), .BYTE_MODE(BYTE_MODE), .HOST_DATA_OUT(HOST_DATA_OUT),
  .HOST_DATA_OE(HOST_DATA_OE), .PORT_WAIT_N(PORT_WAIT_N), .INT_REQ(INT_REQ),
  .INT_ADDR(INT_ADDR), .INVALID_WRITE_FLAG(INVALID_WRITE_FLAG)
);

/* testbench/hqs_host_model.sv */
// Purpose: host bus master driving the quadlet stacking port
// Assumes: free running host clock made by the bench
// Notes: released address and data lines show the inverse of their last value; read/write and byte mode keep theirs
`timescale 1ns/10ps
`include "hqs_map.svh"
module hqs_host_model (
  input wire logic host_clk,
  input wire logic port_wait_n,
  input wire logic [`HQS_DW-1:0] rdata,
  output logic chip_select_n,
  output logic read_write_n,
  output logic byte_mode,
  output logic [`HQS_AW-1:0] addr,
  output logic [`HQS_DW-1:0] wdata
);
  // idle bus at time zero
  initial begin
    chip_select_n = 1'b1;
    read_write_n = 1'b1;
    byte_mode = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // one access; byte data is already on bits 7:0 of wd for byte mode
  task automatic access(input logic rw, input logic bm, input logic [`HQS_AW-1:0] a,
    input logic [`HQS_DW-1:0] wd, output logic [`HQS_DW-1:0] rd, output bit ok);
    int n;
    @(posedge host_clk);
    #1;
    read_write_n = rw;
    byte_mode = bm;
    addr = a;
    wdata = rw ? ~wdata : wd;
    chip_select_n = 1'b0;
    n = 0;
    ok = 1'b0;
    // hold until wait is seen released, never before five clocks low
    while (!ok && n < 40) begin
      @(posedge host_clk);
      n++;
      ok = (port_wait_n === 1'b1) && (n >= 5);
    end
    rd = rdata;
    if (rw) begin
      #1;
    end else begin
      @(negedge host_clk);
    end
    chip_select_n = 1'b1;
    addr = ~addr;
    wdata = ~wdata;
    repeat (4) @(posedge host_clk);
    n = 0;
    while (port_wait_n !== 1'b0 && n < 8) begin
      @(posedge host_clk);
      n++;
    end
    // a wait that never drops again is a hang of the port
    if (port_wait_n !== 1'b0) ok = 1'b0;
  endtask
endmodule

/* testbench/host_port_quadlet_stacking_bench.sv */
// Purpose: self-checking bench of the quadlet stacking host port
// Assumes: core side answered here from a quadlet memory
// Notes: a reference model of the stacking buffer predicts requests, data and flags
`timescale 1ns/10ps
`include "hqs_map.svh"
module host_port_quadlet_stacking_bench
  import hqs_pkg::*;
;
  logic clk = 1'b0;
  logic host_clk = 1'b0;
  logic nrst, chip_select_n, read_write_n, byte_mode, host_oe, port_wait_n, xfer_done;
  logic int_req, int_write, int_done, invalid_write_flag;
  logic [`HQS_AW-1:0] host_addr, int_addr, bq, wq;
  logic [`HQS_DW-1:0] host_din, host_dout;
  logic [`HQS_QW-1:0] int_wdata, int_rdata, bb, wb;
  logic [`HQS_QW-1:0] mem [0:127];
  logic [3:0] rd_m = 4'h0, wr_m = 4'h0;
  hqs_req_t exp_q[$];
  int err_count = 0, checks_done = 0, seed = 39, lat = 2, flags = 0, seen = 0, r;
  bit bv = 1'b0, mute = 1'b0;
  // write/read sequence {rw, byte mode, addr}: fills, orders and broken loads
  localparam logic [10:0] SEQ [0:20] = '{11'h303, 11'h301, 11'h302, 11'h300, 11'h502,
    11'h122, 11'h120, 11'h303, 11'h301, 11'h302, 11'h700, 11'h303, 11'h301, 11'h302,
    11'h303, 11'h120, 11'h140, 11'h142, 11'h540, 11'h0a2, 11'h4a0};

  always #4 clk = ~clk;
  // host clock at 125 ns; only its half-ns edges are sure to miss a core clock edge
  always #62.5 host_clk = ~host_clk;

  hqs_port hqs_port_i (
    .CLK(clk), .NRST(nrst), .HOST_CLOCK_OUT(host_clk), .CHIP_SELECT_N(chip_select_n),
    .READ_WRITE_N(read_write_n), .BYTE_MODE(byte_mode), .HOST_ADDR(host_addr),
    .HOST_DATA_IN(host_din), .HOST_DATA_OUT(host_dout), .HOST_DATA_OE(host_oe),
    .PORT_WAIT_N(port_wait_n), .XFER_DONE(xfer_done), .INT_REQ(int_req),
    .INT_WRITE(int_write), .INT_ADDR(int_addr), .INT_WDATA(int_wdata), .INT_DONE(int_done),
    .INT_RDATA(int_rdata), .INVALID_WRITE_FLAG(invalid_write_flag)
  );
  hqs_host_model hqs_host_model_i (
    // an undriven data bus reads back as the inverse of the last value
    .host_clk(host_clk), .port_wait_n(port_wait_n), .rdata(host_oe ? host_dout : ~host_dout),
    .chip_select_n(chip_select_n), .read_write_n(read_write_n), .byte_mode(byte_mode),
    .addr(host_addr), .wdata(host_din)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // core side: each request is matched to the model, answered after lat cycles unless mute is set
  always begin
    hqs_req_t e;
    @(posedge clk);
    if (int_req === 1'b1) begin
      chk("request expected", 32'd1, 32'(exp_q.size() > 0));
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      chk("int write", 32'(e.write), 32'(int_write));
      chk("int addr", 32'(e.addr), 32'(int_addr));
      if (e.write) chk("int data", e.wdata, int_wdata);
      if (!mute) begin
        repeat (lat) @(posedge clk);
        #1;
        int_rdata = mem[int_addr[8:2]];
        int_done = 1'b1;
        @(posedge clk);
        #1;
        int_done = 1'b0;
        int_rdata = $random(seed);
      end
    end
  end

  // invalid write pulses seen at the port
  always @(posedge clk) begin
    if (invalid_write_flag === 1'b1) seen++;
  end

  // model one access, run it on the bus, then compare
  task automatic acc(input logic rw, input logic bm, input logic [8:0] a,
    input logic [15:0] wd);
    logic [3:0] ln;
    logic [8:0] qa;
    logic [15:0] rd, ex;
    bit ok;
    int sh;
    qa = {a[8:2], 2'b00};
    ln = bm ? (4'h1 << a[1:0]) : (a[1] ? 4'hc : 4'h3);
    sh = bm ? 8 * int'(a[1:0]) : 16 * int'(a[1]);
    ex = 16'h0000;
    // a read, another quadlet or a repeated lane breaks a partial load
    if (wr_m != 4'h0 && (rw || qa != wq || (wr_m & ln) != 4'h0)) begin
      flags++;
      wr_m = 4'h0;
    end
    if (rw) begin
      if (!(bv && qa == bq && (rd_m & ln) == 4'h0)) begin
        bb = mem[qa[8:2]];
        bq = qa;
        bv = 1'b1;
        rd_m = 4'h0;
        exp_q.push_back(hqs_req_t'{1'b0, qa, 32'h0});
      end
      rd_m |= ln;
      ex = bm ? {8'h00, bb[sh+:8]} : bb[sh+:16];
    end else begin
      bv = 1'b0;
      wq = qa;
      if (bm) begin
        wb[sh+:8] = wd[7:0];
      end else begin
        wb[sh+:16] = wd;
      end
      wr_m |= ln;
      if (wr_m == 4'hf) begin
        exp_q.push_back(hqs_req_t'{1'b1, qa, wb});
        mem[qa[8:2]] = wb;
        wr_m = 4'h0;
      end
    end
    hqs_host_model_i.access(rw, bm, a, wd, rd, ok);
    chk("host released", 32'd1, 32'(ok));
    if (!ok) wrap_up();
    if (rw && !mute) chk("read data", 32'(ex), 32'(rd));
    chk("flag count", flags, seen);
    chk("requests left", 32'd0, 32'(exp_q.size()));
    chk("done level", 32'd1, 32'(xfer_done));
  endtask

  initial begin
    nrst = 1'b0;
    int_done = 1'b0;
    int_rdata = '0;
    for (int i = 0; i < 128; i++) mem[i] = $random(seed);
    repeat (16) @(posedge clk);
    repeat (2) @(posedge host_clk);
    #1;
    nrst = 1'b1;
    chk("wait after reset", 32'd0, 32'(port_wait_n));
    chk("done after reset", 32'd1, 32'(xfer_done));
    chk("drive after reset", 32'd0, 32'(host_oe));
    acc(1'b1, 1'b1, 9'h054, 16'h0000);
    acc(1'b1, 1'b1, 9'h055, 16'h0000);
    mem[21] = ~mem[21];
    acc(1'b1, 1'b0, 9'h056, 16'h0000);
    acc(1'b1, 1'b1, 9'h054, 16'h0000);
    acc(1'b1, 1'b0, 9'h0f2, 16'h0000);
    $display("test reads done");
    foreach (SEQ[i]) acc(SEQ[i][10], SEQ[i][9], SEQ[i][8:0], 16'($random(seed)));
    $display("test writes done");
    mute = 1'b1;
    acc(1'b1, 1'b0, 9'h0c0, 16'h0000);
    mute = 1'b0;
    $display("test abort done");
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      lat = 1 + int'(r[11:8]) % 12;
      acc(r[0], r[1], 9'h0e0 + 9'(r[7:4]), r[31:16]);
    end
    $display("test random done");
    wrap_up();
  end
endmodule
